// *** inc/pdss_pkg.sv ***
// Purpose: shared constants for the pipelined double-cycle-deselect sram port
// Assumes: four byte lanes of eight data bits plus one parity line each
// Notes:   burst order codes follow the static strap level
package pdss_pkg;
  localparam int          LANES        = 4;
  localparam int          LANE_W       = 9;
  localparam int          ADDR_W       = 20;
  localparam int          BURST_W      = 2;
  localparam logic        ORDER_LINEAR = 1'b0;
  localparam logic        ORDER_INTLV  = 1'b1;
  localparam logic [1:0]  SYNC_RST     = 2'h0;
  localparam logic [1:0]  SYNC_DONE    = 2'h3;
endpackage : pdss_pkg

// *** hw/pdss_burst_cnt.sv ***
// Purpose: two-bit burst address generator, interleaved or linear
// Assumes: load and step are single-cycle qualifiers from the port logic
// Notes:   interleaved order is start xor step, linear is start plus step
`timescale 1ns/1ps
`default_nettype none
module pdss_burst_cnt #(
  parameter int BURST_W = pdss_pkg::BURST_W
) (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               load_i,
  input  wire logic               step_i,
  input  wire logic               order_i,
  input  wire logic [BURST_W-1:0] start_i,
  output logic      [BURST_W-1:0] low_addr_o
);
  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] step_reg;
  logic [BURST_W-1:0] step_next;

  assign step_next = load_i ? '0 : (step_i ? step_reg + 1'b1 : step_reg); // R4
  // next count, so an advance cycle already reaches the following word
  assign low_addr_o = (order_i == pdss_pkg::ORDER_LINEAR) ? start_reg + step_next
                                                          : start_reg ^ step_next; // R4 R13

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_reg <= '0;
      step_reg  <= '0;
    end else begin
      if (load_i) begin
        start_reg <= start_i; // R3
      end
      step_reg <= step_next;
    end
  end
endmodule : pdss_burst_cnt
`default_nettype wire

// *** hw/pdss_top.sv ***
// Purpose: pipelined sync sram port with double-cycle deselect
// Assumes: far end drives CLOCK_I and all synchronous pins on it
// Notes:   storage is a flip-flop array; shrink ADDR_W for simulation
// Overview of operation
// R1: all synchronous pins land in input registers
// R2: address and selects load only on strobe
// R3: load copies low address bits into counter
// R4: counter steps when advance sampled low
// R5: address, data, write controls registered, self-timed write
// R6: byte-lane selects choose one to four lanes
// R7: all-bytes write overrides lane selects and gate
// R8: lane selects count only with write gate
// R9: far end drives gate low for lane writes
// R10: output enable held one extra cycle on deselect
// R11: output drive and sleep act unregistered
// R12: registered outputs, first word three cycles
// R13: counter offers interleaved and linear order
// R14: three selects, all active to accept address
// R15: both strobes together: processor strobe wins
// R16: processor strobe ignored when primary select high
// R17: grounded strap linear, otherwise interleaved
// R18: output drive masked first read clock after deselect
`timescale 1ns/1ps
`default_nettype none
module pdss_top #(
  parameter int ADDR_W = pdss_pkg::ADDR_W,
  parameter int LANES  = pdss_pkg::LANES,
  parameter int LANE_W = pdss_pkg::LANE_W
) (
  input  wire logic                    CLOCK_I,
  input  wire logic                    RESET_N_I,
  input  wire logic [ADDR_W-1:0]       ADDR_I,
  input  wire logic [LANES*LANE_W-1:0] DQ_I,
  output logic      [LANES*LANE_W-1:0] DQ_O,
  output logic                         DQ_OE_N_O,
  input  wire logic                    PROCESSOR_ADDR_STROBE_N_I,
  input  wire logic                    CONTROLLER_ADDR_STROBE_N_I,
  input  wire logic                    BURST_ADVANCE_N_I,
  input  wire logic                    ALL_BYTES_WRITE_N_I,
  input  wire logic                    BYTE_WRITE_GATE_N_I,
  input  wire logic [LANES-1:0]        BYTE_LANE_SELECT_N_I,
  input  wire logic                    PRIMARY_SELECT_N_I,
  input  wire logic                    EXPANSION_SELECT_HI_I,
  input  wire logic                    EXPANSION_SELECT_LO_N_I,
  input  wire logic                    OUTPUT_DRIVE_N_I,
  input  wire logic                    SLEEP_REQUEST_I,
  input  wire logic                    BURST_ORDER_I
);
  localparam int DATA_W = LANES * LANE_W;
  localparam int BW     = pdss_pkg::BURST_W;

  typedef enum logic {PDSS_IDLE, PDSS_BURST} pdss_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_reg <= pdss_pkg::SYNC_RST;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // input registers, same clock as the far end so no synchroniser
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              pstb_n_reg;
  logic              cstb_n_reg;
  logic              adv_n_reg;
  logic              all_wr_n_reg;
  logic              gate_n_reg;
  logic [LANES-1:0]  lane_n_reg;
  logic              sel1_n_reg;
  logic              sel2_reg;
  logic              sel3_n_reg;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg     <= '0;
      wdata_reg    <= '0;
      pstb_n_reg   <= 1'b1;
      cstb_n_reg   <= 1'b1;
      adv_n_reg    <= 1'b1;
      all_wr_n_reg <= 1'b1;
      gate_n_reg   <= 1'b1;
      lane_n_reg   <= '1;
      sel1_n_reg   <= 1'b1;
      sel2_reg     <= 1'b0;
      sel3_n_reg   <= 1'b1;
    end else begin
      addr_reg     <= ADDR_I; // R1
      wdata_reg    <= DQ_I; // R5
      pstb_n_reg   <= PROCESSOR_ADDR_STROBE_N_I;
      cstb_n_reg   <= CONTROLLER_ADDR_STROBE_N_I;
      adv_n_reg    <= BURST_ADVANCE_N_I;
      all_wr_n_reg <= ALL_BYTES_WRITE_N_I;
      gate_n_reg   <= BYTE_WRITE_GATE_N_I; // R8
      lane_n_reg   <= BYTE_LANE_SELECT_N_I;
      sel1_n_reg   <= PRIMARY_SELECT_N_I;
      sel2_reg     <= EXPANSION_SELECT_HI_I;
      sel3_n_reg   <= EXPANSION_SELECT_LO_N_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst order strap, caught once after reset release
  logic order_reg;
  logic order_taken_reg;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      order_reg       <= pdss_pkg::ORDER_INTLV;
      order_taken_reg <= 1'b0;
    end else if (!order_taken_reg) begin
      order_reg       <= BURST_ORDER_I ? pdss_pkg::ORDER_INTLV
                                       : pdss_pkg::ORDER_LINEAR; // R17
      order_taken_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode on the registered pins
  pdss_state_e       state_reg;
  pdss_state_e       state_next;
  logic              asleep;
  logic              p_start;
  logic              c_start;
  logic              load;
  logic              sel_ok;
  logic              start_ok;
  logic              deselect;
  logic              cont;
  logic              step;
  logic [LANES-1:0]  lanes;
  logic              wr;
  logic              rd;
  logic [BW-1:0]     low_addr;
  logic [ADDR_W-1:0] hi_addr_reg;
  logic [ADDR_W-1:0] acc_addr;

  // sleep gates accesses unregistered; far end keeps it quiet near edges
  assign asleep   = SLEEP_REQUEST_I; // R11
  assign p_start  = !pstb_n_reg && !sel1_n_reg && !asleep; // R16
  assign c_start  = !cstb_n_reg && !p_start && !asleep; // R15
  assign load     = p_start || c_start; // R2
  assign sel_ok   = !sel1_n_reg && sel2_reg && !sel3_n_reg; // R14
  assign start_ok = load && sel_ok;
  assign deselect = load && !sel_ok;
  assign cont     = !load && (state_reg == PDSS_BURST) && !asleep;
  assign step     = cont && !adv_n_reg; // R4

  // processor-strobe start is always a read; lane writes wait for later cycles
  assign lanes = !all_wr_n_reg ? '1 : (!gate_n_reg ? ~lane_n_reg : '0); // R6 R7 R8
  assign wr    = (c_start && sel_ok || cont) && |lanes;
  assign rd    = (start_ok || cont) && !wr;

  assign acc_addr = load ? addr_reg : {hi_addr_reg[ADDR_W-1:BW], low_addr}; // R3

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PDSS_IDLE: begin
        if (start_ok) begin
          state_next = PDSS_BURST;
        end
      end
      PDSS_BURST: begin
        if (deselect) begin
          state_next = PDSS_IDLE;
        end
      end
      default: begin
        state_next = PDSS_IDLE;
      end
    endcase
  end

  pdss_burst_cnt #(
    .BURST_W    (BW)
  ) u_burst (
    .clk_i      (CLOCK_I),
    .rst_n_i    (rst_n),
    .load_i     (start_ok),
    .step_i     (step),
    .order_i    (order_reg),
    .start_i    (addr_reg[BW-1:0]),
    .low_addr_o (low_addr)
  );

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= PDSS_IDLE;
      hi_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (start_ok) begin
        hi_addr_reg <= addr_reg; // R2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage, written in one edge from registered controls
  // one array per lane so each lane process owns its own storage
  logic [LANE_W-1:0] mem [LANES][2**ADDR_W];
  logic [DATA_W-1:0] rd_word;

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign rd_word[g*LANE_W +: LANE_W] = mem[g][acc_addr];
      always_ff @(posedge CLOCK_I) begin
        if (wr && lanes[g]) begin
          mem[g][acc_addr] <= wdata_reg[g*LANE_W +: LANE_W]; // R5 R6
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline: input reg, array reg, output reg gives 3-1-1-1
  logic [DATA_W-1:0] rdata_reg;
  logic              rvalid_reg;
  logic              first_rd_reg;
  logic [DATA_W-1:0] dout_reg;
  logic              dout_en_reg;
  logic              hold_reg;
  logic              mask_reg;
  logic              drive;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg    <= '0;
      rvalid_reg   <= 1'b0;
      first_rd_reg <= 1'b0;
      dout_reg     <= '0;
      dout_en_reg  <= 1'b0;
      hold_reg     <= 1'b0;
      mask_reg     <= 1'b0;
    end else begin
      if (rd) begin
        rdata_reg <= rd_word;
      end
      rvalid_reg   <= rd;
      first_rd_reg <= rd && (state_reg == PDSS_IDLE);
      if (rvalid_reg) begin
        dout_reg <= rdata_reg; // R12
      end
      dout_en_reg <= rvalid_reg;
      // extra enable stage keeps the buffers on one cycle past a deselect
      hold_reg    <= dout_en_reg && !rvalid_reg && (state_reg == PDSS_IDLE); // R10
      mask_reg    <= first_rd_reg; // R18
    end
  end

  assign drive     = (dout_en_reg || hold_reg) && !mask_reg;
  assign DQ_O      = dout_reg;
  assign DQ_OE_N_O = !(drive && !OUTPUT_DRIVE_N_I && !SLEEP_REQUEST_I); // R11
endmodule : pdss_top
`default_nettype wire

// *** dv/pdss_chk.sv ***
// Purpose: port assertions for the pipelined sram port
// Assumes: bound to pdss_top, one clock domain
// Notes:   sleep and output drive are seen at clock samples
`timescale 1ns/1ps
`default_nettype none
module pdss_chk #(
  parameter int LANES  = pdss_pkg::LANES,
  parameter int LANE_W = pdss_pkg::LANE_W
) (
  input  wire logic                    CLOCK_I,
  input  wire logic                    RESET_N_I,
  input  wire logic [LANES*LANE_W-1:0] DQ_O,
  input  wire logic                    DQ_OE_N_O,
  input  wire logic                    PROCESSOR_ADDR_STROBE_N_I,
  input  wire logic                    CONTROLLER_ADDR_STROBE_N_I,
  input  wire logic                    BURST_ADVANCE_N_I,
  input  wire logic                    PRIMARY_SELECT_N_I,
  input  wire logic                    OUTPUT_DRIVE_N_I,
  input  wire logic                    SLEEP_REQUEST_I
);
  ////////////////////////////////////////
  // lenient: controller strobe, advance, or processor strobe with primary select low may move the output pipeline
  wire logic cause;
  assign cause = (!PROCESSOR_ADDR_STROBE_N_I && !PRIMARY_SELECT_N_I)
                 || !CONTROLLER_ADDR_STROBE_N_I || !BURST_ADVANCE_N_I;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);
  property p_sleep_off; SLEEP_REQUEST_I |-> DQ_OE_N_O; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("driven in sleep");
  property p_drive_off; OUTPUT_DRIVE_N_I |-> DQ_OE_N_O; endproperty
  a_drive_off: assert property (p_drive_off) else $error("driven while off");
  property p_sleep_hold; SLEEP_REQUEST_I [*4] |=> $stable(DQ_O); endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("data moved in sleep");
  property p_sleep_quiet; SLEEP_REQUEST_I [*6] ##1 !SLEEP_REQUEST_I |-> DQ_OE_N_O; endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("stale drive");
  property p_oe_cause;
    $fell(DQ_OE_N_O) && !OUTPUT_DRIVE_N_I && !$past(OUTPUT_DRIVE_N_I) && !$past(SLEEP_REQUEST_I)
    |-> $past(cause, 3) || $past(cause, 4) || $past(cause, 5);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without access");
  property p_dq_cause;
    $changed(DQ_O) |-> $past(cause, 3) || $past(cause, 4) || $past(cause, 5);
  endproperty
  a_dq_cause: assert property (p_dq_cause) else $error("data without access");
  property p_rst_oe; $rose(RESET_N_I) |-> DQ_OE_N_O ##1 DQ_OE_N_O; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("drive after reset");
  property p_rst_dq; $rose(RESET_N_I) |-> DQ_O == '0 ##1 DQ_O == '0; endproperty
  a_rst_dq: assert property (p_rst_dq) else $error("data after reset");
endmodule : pdss_chk
bind pdss_top pdss_chk #(.LANES(LANES), .LANE_W(LANE_W)) u_pdss_chk (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .DQ_O(DQ_O), .DQ_OE_N_O(DQ_OE_N_O),
  .PROCESSOR_ADDR_STROBE_N_I(PROCESSOR_ADDR_STROBE_N_I),
  .CONTROLLER_ADDR_STROBE_N_I(CONTROLLER_ADDR_STROBE_N_I),
  .BURST_ADVANCE_N_I(BURST_ADVANCE_N_I), .PRIMARY_SELECT_N_I(PRIMARY_SELECT_N_I),
  .OUTPUT_DRIVE_N_I(OUTPUT_DRIVE_N_I), .SLEEP_REQUEST_I(SLEEP_REQUEST_I));
`default_nettype wire

// *** dv/pdss_host_model.sv ***
// Purpose: bus master model driving the sram port pins
// Assumes: cyc is entered at a rising edge, once per clock
// Notes:   ctl bits: processor, controller, advance, all-bytes, gate
`timescale 1ns/1ps
`default_nettype none
module pdss_host_model (
  input  wire logic        clk_i,
  output logic      [5:0]  addr_o,
  output logic      [35:0] dq_o,
  output logic      [4:0]  ctl_n_o,
  output logic      [3:0]  lane_n_o,
  output logic      [2:0]  sel_o
);
  ////////////////////////////////////////
  task automatic cyc(input logic [5:0] a, input logic [4:0] c, input logic [3:0] l,
                     input logic [2:0] s, input logic [35:0] d);
    addr_o   <= a;
    ctl_n_o  <= c;
    lane_n_o <= l;
    sel_o    <= s;
    // released data lines must not look like the last write
    dq_o     <= (&c[1:0]) ? ~dq_o : d;
    @(posedge clk_i);
  endtask : cyc
  initial begin
    dq_o = 36'h0;
    cyc(6'h00, 5'h1F, 4'hF, 3'h2, 36'h0);
  end
endmodule : pdss_host_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the pipelined sram port
// Assumes: address width shrunk to 6, array filled before reads
// Notes:   expected data comes from a bench copy of the array
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, drv_n = 1'b0, slp = 1'b0, ord = 1'b0;
  logic [5:0]  addr;
  logic [35:0] dq_w, dq_r, last_exp;
  logic        oe_n;
  logic [4:0]  ctl;
  logic [3:0]  lane;
  logic [2:0]  sel;
  logic [35:0] mem [64];
  logic [15:0] rnd = 16'h0012;
  int          n_mismatch = 0;
  int          tests_run = 0;
  localparam logic [4:0] CW [4] = '{5'h14, 5'h16, 5'h16, 5'h17};
  localparam logic [4:0] RC [4] = '{5'h0F, 5'h17, 5'h05, 5'h0F};
  localparam logic [2:0] SL [8] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h3, 3'h6};
  always #5 clk = ~clk;
  pdss_host_model u_pdss_host_model (.clk_i(clk), .addr_o(addr), .dq_o(dq_w), .ctl_n_o(ctl),
    .lane_n_o(lane), .sel_o(sel));
  pdss_top #(.ADDR_W(6)) u_pdss_top (.CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .DQ_I(dq_w), .DQ_O(dq_r), .DQ_OE_N_O(oe_n), .PROCESSOR_ADDR_STROBE_N_I(ctl[4]),
    .CONTROLLER_ADDR_STROBE_N_I(ctl[3]), .BURST_ADVANCE_N_I(ctl[2]),
    .ALL_BYTES_WRITE_N_I(ctl[1]), .BYTE_WRITE_GATE_N_I(ctl[0]), .BYTE_LANE_SELECT_N_I(lane),
    .PRIMARY_SELECT_N_I(sel[2]), .EXPANSION_SELECT_HI_I(sel[1]),
    .EXPANSION_SELECT_LO_N_I(sel[0]), .OUTPUT_DRIVE_N_I(drv_n), .SLEEP_REQUEST_I(slp),
    .BURST_ORDER_I(ord));
  ////////////////////////////////////////
  function automatic logic [15:0] nxt();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction : nxt
  function automatic logic [35:0] rnd36();
    logic [47:0] v;
    v = {nxt(), nxt(), nxt()};
    return v[35:0];
  endfunction : rnd36
  function automatic logic [5:0] baddr(input logic [5:0] a, input logic [1:0] n);
    return {a[5:2], ord ? (a[1:0] ^ n) : (a[1:0] + n)};
  endfunction : baddr
  function automatic logic [35:0] merge(input logic [35:0] o, d, input logic [3:0] l);
    for (int g = 0; g < 4; g++)
      if (!l[g]) o[g*9+:9] = d[g*9+:9];
    return o;
  endfunction : merge
  task automatic chk(input logic [35:0] e);
    tests_run++;
    if (dq_r !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: data %h, expected %h", $time, dq_r, e);
    end
  endtask : chk
  task automatic chk_oe(input logic e);
    tests_run++;
    if (oe_n !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: drive enable %b, expected %b", $time, oe_n, e);
    end
  endtask : chk_oe
  task automatic wr(input logic [5:0] a, input logic [4:0] c, input logic [3:0] l,
                    input logic [2:0] s);
    logic [35:0] d;
    d = rnd36();
    u_pdss_host_model.cyc(a, c, l, s, d);
    if (s == 3'h2 && !slp) mem[a] = merge(mem[a], d, !c[1] ? 4'h0 : (c[0] ? 4'hF : l));
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [4:0] c);
    last_exp = mem[baddr(a, 2'd3)];
    fork
      begin
        u_pdss_host_model.cyc(a, c, 4'hF, 3'h2, 36'h0);
        repeat (3) u_pdss_host_model.cyc(a, 5'h1B, 4'hF, 3'h2, 36'h0);
        u_pdss_host_model.cyc(a, 5'h1F, 4'hF, 3'h2, 36'h0);
      end
      begin
        repeat (3) @(posedge clk);
        for (int n = 0; n < 4; n++) begin
          #1 chk(mem[baddr(a, 2'(n))]);
          @(posedge clk);
        end
      end
    join
  endtask : rd
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      rst_n <= 1'b0;
      ord   <= ph[0];
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      drv_n <= 1'b1;
      repeat (4) @(posedge clk);
      drv_n <= 1'b0;
      for (int a = 0; a < 64; a++) wr(6'(a), 5'h14, rnd[3:0], 3'h2);
      repeat (40) begin
        wr(rnd[5:0], CW[rnd[7:6]], rnd[11:8], SL[rnd[14:12]]);
        rd(rnd[5:0], RC[rnd[1:0]]);
      end
      rd(6'h05, 5'h0F);
      repeat (5) u_pdss_host_model.cyc(6'h2A, 5'h0F, 4'hF, 3'h6, 36'h0);
      #1 chk(last_exp);
      chk_oe(1'b0);
      @(posedge clk);
      slp <= 1'b1;
      u_pdss_host_model.cyc(6'h00, 5'h1F, 4'hF, 3'h2, 36'h0);
      wr(6'h09, 5'h14, 4'h0, 3'h2);
      repeat (6) u_pdss_host_model.cyc(6'h09, 5'h0F, 4'hF, 3'h2, 36'h0);
      slp <= 1'b0;
      rd(6'h09, 5'h0F);
    end
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
